/* hdl/aoc_map.svh */
/*
 Register offsets, field positions, reset values and word constants
 of the arithmetic overflow control block.
 Assumes inclusion by bare name from aoc_alu, aoc_top and tb_top; the package does not include it.
*/
`ifndef AOC_MAP_SVH
`define AOC_MAP_SVH

// ------------------------------------------------------------
// Word layout
// ------------------------------------------------------------
`define AOC_W            48
`define AOC_PC_W         15
`define AOC_AW           8
`define AOC_MINUS_ONE    48'h8000_0000_0000
`define AOC_MAX_POS      48'h7FFF_FFFF_FFFF

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define AOC_OFF_CMD      8'h00
`define AOC_OFF_STATUS   8'h04
`define AOC_OFF_PC       8'h20
`define AOC_OFF_DATA     8'h08
`define AOC_DATA_STRIDE  8'h08
`define AOC_OFF_HI       8'h04

// ------------------------------------------------------------
// Command and status fields
// ------------------------------------------------------------
`define AOC_CMD_OP_LSB   0
`define AOC_CMD_OP_MSB   4
`define AOC_CMD_STORE    5
`define AOC_CMD_TGT_LSB  16
`define AOC_CMD_TGT_MSB  30
`define AOC_ST_IND       0
`define AOC_ST_INH       1
`define AOC_ST_HALT      2
`define AOC_ST_BUSY      3
`define AOC_ST_EXAM      4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define AOC_PC_RST       15'h0000

`endif

/* hdl/aoc_pkg.sv */
/*
 Types of the arithmetic overflow control block: operation codes and
 sequencer states. Assumes aoc_map.svh on the include path.
*/
package aoc_pkg;

    // ------------------------------------------------------------
    // Operations, codes count up from zero in this order
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        op_nop = 5'h00,
        op_add,
        op_sub,
        op_multiply,
        op_multiply_then_add,
        op_multiply_then_subtract,
        op_div_single,
        op_div_double,
        op_shift_left,
        op_shift_right,
        op_index_add_left_half,
        op_index_add_right_half,
        op_index_sub_left_half,
        op_index_sub_right_half,
        op_jump_if_overflow,
        op_jump_if_no_overflow,
        op_inhibit_overflow_clear,
        op_allow_overflow_clear
    } aoc_op_t;

    typedef enum logic [1:0] {
        st_idle,
        st_exec,
        st_halt
    } aoc_state_t;

endpackage

/* hdl/aoc_alu.sv */
/*
 Combinational arithmetic of the overflow control block: results for
 accumulator, extension and operand word plus the overflow event.
 Assumes the caller registers all results.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aoc_map.svh"

module aoc_alu
    import aoc_pkg::*;
(
    input  wire aoc_op_t           op,
    input  wire logic              store,
    input  wire logic [`AOC_W-1:0] acc,
    input  wire logic [`AOC_W-1:0] ext,
    input  wire logic [`AOC_W-1:0] opnd,
    output logic      [`AOC_W-1:0] acc_n,
    output logic      [`AOC_W-1:0] ext_n,
    output logic      [`AOC_W-1:0] opnd_n,
    output logic                   ovf
);

    // Returns {overflow, sum}; overflow is carry into sign xor carry out
    function automatic logic [`AOC_W:0] addsub(input logic [`AOC_W-1:0] a,
                                               input logic [`AOC_W-1:0] b,
                                               input logic              sub);
        logic [`AOC_W-1:0] bb;
        logic [`AOC_W-1:0] lo;
        logic [`AOC_W:0]   full;
        bb   = sub ? ~b : b;
        lo   = {1'b0, a[`AOC_W-2:0]} + {1'b0, bb[`AOC_W-2:0]} + {47'h0, sub};
        full = {1'b0, a} + {1'b0, bb} + {48'h0, sub};
        return {lo[`AOC_W-1] ^ full[`AOC_W], full[`AOC_W-1:0]};
    endfunction

    // Magnitude as unsigned; minus one gives the top bit alone
    function automatic logic [`AOC_W-1:0] mag(input logic [`AOC_W-1:0] x);
        return x[`AOC_W-1] ? (~x + 48'h1) : x;
    endfunction

    logic        [`AOC_W-1:0]   mul_a;
    logic signed [2*`AOC_W-1:0] prod;
    logic        [`AOC_W-1:0]   prod_hi;
    logic        [`AOC_W-1:0]   prod_lo;
    logic                       mul_ovf;
    logic        [`AOC_W:0]     sum;
    logic                       pot_ovf;
    logic                       eq_neg;
    logic        [`AOC_W-1:0]   shr_acc;

    // Binary point sits after the sign: product bits 94..47 form A
    assign mul_a   = (op == op_multiply) ? acc : ext;
    assign prod    = 96'($signed(mul_a) * $signed(opnd));
    assign prod_hi = prod[2*`AOC_W-2:`AOC_W-1];
    assign prod_lo = {prod[2*`AOC_W-2], prod[`AOC_W-2:0]};
    assign mul_ovf = (mul_a == `AOC_MINUS_ONE) && (opnd == `AOC_MINUS_ONE);

    assign pot_ovf = (mag(acc) > mag(opnd)) ||
                     ((mag(acc) == mag(opnd)) && !acc[`AOC_W-1]);
    assign eq_neg  = (mag(acc) == mag(opnd)) && acc[`AOC_W-1];
    assign shr_acc = {acc[`AOC_W-1], acc[`AOC_W-1:1]};

    always_comb begin
        sum    = '0;
        acc_n  = acc;
        ext_n  = ext;
        opnd_n = opnd;
        ovf    = 1'b0;
        case (op)
            op_add, op_sub: begin
                sum   = addsub(acc, opnd, op == op_sub);
                acc_n = sum[`AOC_W-1:0];
                ovf   = sum[`AOC_W];
            end
            op_multiply: begin
                acc_n = prod_hi;
                ext_n = prod_lo;
                ovf   = mul_ovf;
            end
            op_multiply_then_add, op_multiply_then_subtract: begin
                sum   = addsub(acc, prod_hi, op == op_multiply_then_subtract);
                acc_n = sum[`AOC_W-1:0];
                ext_n = prod_lo;
                ovf   = mul_ovf | sum[`AOC_W];
            end
            op_div_single, op_div_double: begin
                if (pot_ovf) begin
                    acc_n = shr_acc;
                    ext_n = (op == op_div_single) ? 48'h0 : {acc[0], ext[`AOC_W-1:1]};
                    ovf   = 1'b1;
                    if (store) begin
                        opnd_n = ext_n;
                    end
                end else if (eq_neg) begin
                    acc_n = opnd[`AOC_W-1] ? opnd : (~opnd + 48'h1);
                    ext_n = opnd[`AOC_W-1] ? `AOC_MAX_POS : `AOC_MINUS_ONE;
                end
            end
            op_shift_left: begin
                acc_n = {acc[`AOC_W-2:0], 1'b0};
                ovf   = acc[`AOC_W-1] ^ acc[`AOC_W-2];
            end
            op_shift_right: acc_n = shr_acc;
            op_index_add_left_half: acc_n = {acc[47:24] + opnd[47:24], acc[23:0]};
            op_index_sub_left_half: acc_n = {acc[47:24] - opnd[47:24], acc[23:0]};
            op_index_add_right_half: acc_n = {acc[47:24], acc[23:0] + opnd[23:0]};
            op_index_sub_right_half: acc_n = {acc[47:24], acc[23:0] - opnd[23:0]};
            default: ovf = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

/* hdl/aoc_top.sv */
/*
 Arithmetic overflow control: APB slave holding accumulator, extension
 and operand words, an instruction sequencer for arithmetic, shift,
 index, jump and overflow-clear instructions, the overflow indicator,
 the clear-inhibit state and the console stop/halt behaviour.
 Assumes a single APB master on pclk; console inputs are synchronous.

// Function
// - Words are signed fractions, point after sign
// - Minus one is sign one, rest zero
// - Results outside range raise overflow
// - Add/sub overflow: sign carries in and out differ
// - Minus one squared overflows, product reads minus one
// - Product overflow persists through the accumulate step
// - Dividend above divisor: skip divide, adjust registers
// - Divide overflow shifts accumulator, extension per length
// - Store option writes extension over divisor
// - Equal magnitudes give fixed special results
// - Indicator cleared before clearing-class instructions
// - Indicator set on every overflow
// - Jump on overflow when indicator set
// - Jump on no overflow when indicator clear
// - Inhibit instruction clears indicator, then inhibits
// - Only the allow instruction removes inhibit
// - Stop switch ignored while inhibited
// - Switch off: overflow continues normally
// - Switch on: halt unless next is jump
// - Lamp follows the overflow indicator
// - Divide overflow sets the indicator
*/
// Chosen here: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "aoc_map.svh"

module aoc_top
    import aoc_pkg::*;
(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [`AOC_AW-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               ovf_stop_sw,
    input  wire logic               op_resume,
    output logic                    ovf_lamp,
    output logic                    halt_lamp
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_jump(input aoc_op_t op);
        return (op == op_jump_if_overflow) || (op == op_jump_if_no_overflow);
    endfunction

    function automatic logic is_clearing(input aoc_op_t op);
        logic r;
        case (op)
            op_add, op_sub, op_multiply, op_multiply_then_add,
            op_multiply_then_subtract, op_div_single, op_div_double,
            op_shift_left, op_shift_right,
            op_index_add_left_half, op_index_add_right_half,
            op_index_sub_left_half, op_index_sub_right_half: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Byte address of the low or high word of data register idx
    function automatic logic data_hit(input logic [`AOC_AW-1:0] a,
                                      input logic [1:0]         idx,
                                      input logic               hi);
        logic [`AOC_AW-1:0] off;
        off = `AOC_OFF_DATA + 8'(idx) * `AOC_DATA_STRIDE;
        if (hi) begin
            off = off + `AOC_OFF_HI;
        end
        return a == off;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    aoc_state_t              state_q;
    aoc_op_t                 op_q;
    logic                    store_q;
    logic [`AOC_PC_W-1:0]    tgt_q;
    logic [`AOC_PC_W-1:0]    pc_q;
    logic [`AOC_W-1:0]       data_q [0:2];
    logic [`AOC_W-1:0]       res [0:2];
    logic                    ind_q;
    logic                    inh_q;
    logic                    exam_q;
    logic                    halt_q;
    logic                    pready_q;
    logic                    pslverr_q;
    logic [31:0]             prdata_q;
    logic [31:0]             rd_d;
    logic                    err_d;
    logic                    alu_ovf;
    logic                    wr;
    logic                    idle;
    logic                    stop_now;
    logic                    exec;
    logic                    taken;

    // ------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------
    // One access cycle: ready rises at the setup edge, so every
    // transfer finishes on its first access-phase edge.
    assign wr   = psel && penable && pready_q && pwrite;
    assign idle = (state_q == st_idle);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && err_d;
            if (psel && !penable && !pwrite) begin
                prdata_q <= rd_d;
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr == `AOC_OFF_CMD) begin
            rd_d[`AOC_CMD_OP_MSB:`AOC_CMD_OP_LSB]   = op_q;
            rd_d[`AOC_CMD_STORE]                    = store_q;
            rd_d[`AOC_CMD_TGT_MSB:`AOC_CMD_TGT_LSB] = tgt_q;
        end else if (paddr == `AOC_OFF_STATUS) begin
            rd_d[`AOC_ST_IND]  = ind_q;
            rd_d[`AOC_ST_INH]  = inh_q;
            rd_d[`AOC_ST_HALT] = halt_q;
            rd_d[`AOC_ST_BUSY] = !idle;
            rd_d[`AOC_ST_EXAM] = exam_q;
        end else if (paddr == `AOC_OFF_PC) begin
            rd_d[`AOC_PC_W-1:0] = pc_q;
        end else begin
            err_d = 1'b1;
            for (int i = 0; i < 3; i++) begin
                if (data_hit(paddr, 2'(i), 1'b0)) begin
                    rd_d  = data_q[i][31:0];
                    err_d = 1'b0;
                end else if (data_hit(paddr, 2'(i), 1'b1)) begin
                    rd_d[15:0] = data_q[i][`AOC_W-1:32];
                    err_d      = 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    aoc_alu u_alu (
        .op     (op_q),
        .store  (store_q),
        .acc    (data_q[0]),
        .ext    (data_q[1]),
        .opnd   (data_q[2]),
        .acc_n  (res[0]),
        .ext_n  (res[1]),
        .opnd_n (res[2]),
        .ovf    (alu_ovf)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // A pending stop lets only a jump instruction through.
    assign stop_now = exam_q && !is_jump(op_q);
    assign exec     = (state_q == st_exec) && !stop_now;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= st_idle;
        end else begin
            case (state_q)
                st_idle: begin
                    if (wr && paddr == `AOC_OFF_CMD) begin
                        state_q <= st_exec;
                    end
                end
                st_exec: begin
                    if (stop_now) begin
                        state_q <= st_halt;
                    end else begin
                        state_q <= st_idle;
                    end
                end
                st_halt: begin
                    if (op_resume) begin
                        state_q <= st_exec;
                    end
                end
                default: state_q <= st_idle;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_q <= 1'b0;
        end else if (state_q == st_exec && stop_now) begin
            halt_q <= 1'b1;
        end else if (op_resume) begin
            halt_q <= 1'b0;
        end
    end

    assign halt_lamp = halt_q;

    // Commands written while busy are dropped; software polls busy.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q    <= op_nop;
            store_q <= 1'b0;
            tgt_q   <= `AOC_PC_RST;
        end else if (idle && wr && paddr == `AOC_OFF_CMD) begin
            op_q    <= aoc_op_t'(pwdata[`AOC_CMD_OP_MSB:`AOC_CMD_OP_LSB]);
            store_q <= pwdata[`AOC_CMD_STORE];
            tgt_q   <= pwdata[`AOC_CMD_TGT_MSB:`AOC_CMD_TGT_LSB];
        end
    end

    // ------------------------------------------------------------
    // Overflow indicator and clear inhibit
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_q <= 1'b0;
        end else if (exec) begin
            if (op_q == op_inhibit_overflow_clear) begin
                ind_q <= 1'b0;
            end else if (is_clearing(op_q)) begin
                // Clear first unless inhibited, so an overflow of this op still sets it
                ind_q <= (inh_q ? ind_q : 1'b0) | alu_ovf;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inh_q <= 1'b0;
        end else if (exec && op_q == op_inhibit_overflow_clear) begin
            inh_q <= 1'b1;
        end else if (exec && op_q == op_allow_overflow_clear) begin
            inh_q <= 1'b0;
        end
    end

    assign ovf_lamp = ind_q;

    // Stop request is armed only with the switch on and no inhibit;
    // the next instruction consumes it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exam_q <= 1'b0;
        end else if (exec) begin
            exam_q <= alu_ovf && !inh_q && ovf_stop_sw;
        end else if (state_q == st_halt && op_resume) begin
            exam_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Instruction counter
    // ------------------------------------------------------------
    assign taken = (op_q == op_jump_if_overflow && ind_q) ||
                   (op_q == op_jump_if_no_overflow && !ind_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= `AOC_PC_RST;
        end else if (exec) begin
            pc_q <= taken ? tgt_q : pc_q + 15'h0001;
        end else if (idle && wr && paddr == `AOC_OFF_PC) begin
            pc_q <= pwdata[`AOC_PC_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Accumulator, extension and operand words
    // ------------------------------------------------------------
    for (genvar gi = 0; gi < 3; gi++) begin : g_word
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                data_q[gi] <= 48'h0000_0000_0000;
            end else if (exec) begin
                data_q[gi] <= res[gi];
            end else if (idle && wr && data_hit(paddr, 2'(gi), 1'b0)) begin
                data_q[gi][31:0] <= pwdata;
            end else if (idle && wr && data_hit(paddr, 2'(gi), 1'b1)) begin
                data_q[gi][`AOC_W-1:32] <= pwdata[15:0];
            end
        end
    end

endmodule
`default_nettype wire

/* tb/aoc_monitor.sv */
/*
 Checker on the ports of the overflow control top.
 Assumes a bind onto aoc_top and one pclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module aoc_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic op_resume,
    input wire logic ovf_lamp,
    input wire logic halt_lamp
);
    // ----
    // Port relations
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup:
        assert property (psel && !penable |=> pready) else $error("ready late");
    a_ready_single:
        assert property (pready |=> !pready) else $error("ready too long");
    a_ready_cause:
        assert property (pready |-> $past(psel) && !$past(penable)) else $error("stray ready");
    a_err_ready:
        assert property (pslverr |-> pready) else $error("error without ready");
    a_reset_quiet:
        assert property ($rose(presetn) |-> !ovf_lamp && !halt_lamp) else $error("lamp after reset");
    a_halt_holds:
        assert property (halt_lamp && !op_resume |=> halt_lamp) else $error("halt dropped");
    a_halt_leave:
        assert property (halt_lamp && op_resume |=> !halt_lamp) else $error("resume ignored");
    a_halt_lit:
        assert property ($rose(halt_lamp) |-> ovf_lamp) else $error("halt with lamp dark");
    a_halt_steady:
        assert property (halt_lamp |=> $stable(ovf_lamp)) else $error("indicator moved in halt");
endmodule
bind aoc_top aoc_monitor i_mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .op_resume, .ovf_lamp, .halt_lamp);
`default_nettype wire

/* tb/aoc_console.sv */
/*
 Operator console model: stop switch and resume after an overflow halt.
 Assumes the halt lamp is a pclk register.
*/
`timescale 1ns/100ps
`default_nettype none
module aoc_console (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       sw_on,
    input  wire logic [3:0] wait_cyc,
    input  wire logic       halt_lamp,
    output logic            ovf_stop_sw,
    output logic            op_resume,
    output var int          halts
);
    logic [3:0] cnt_q;
    // ----
    // Operator
    // ----
    assign ovf_stop_sw = sw_on;
    // A slow operator leaves the machine halted for wait_cyc + 2 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q     <= 4'h0;
            op_resume <= 1'b0;
            halts     <= 0;
        end else if (halt_lamp && !op_resume && cnt_q == wait_cyc) begin
            cnt_q     <= 4'h0;
            op_resume <= 1'b1;
            halts     <= halts + 1;
        end else begin
            cnt_q     <= (halt_lamp && !op_resume) ? cnt_q + 4'h1 : 4'h0;
            op_resume <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
 Self-checking bench of the overflow control block over APB.
 Assumes the console model and the checker bind are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "aoc_map.svh"
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("Error at %0t: got %h expected %h", $time, g, e); \
    end \
end
module tb_top
    import aoc_pkg::*;
;
    typedef struct packed {aoc_op_t op; logic [47:0] a, e, o, ra, re; logic v;} aoc_row_t;
    localparam logic [47:0] MX = `AOC_MAX_POS;
    localparam logic [47:0] MN = `AOC_MINUS_ONE;
    localparam logic [47:0] HF = 48'h4000_0000_0000;
    localparam logic [47:0] QT = 48'h2000_0000_0000;
    localparam logic [47:0] NH = 48'hC000_0000_0000;
    localparam logic [47:0] LH = 48'h0000_0100_0000;
    localparam logic [47:0] Z0 = 48'h0000_0000_0000;
    localparam logic [47:0] ONE = 48'h0000_0000_0001;
    logic        pclk, presetn, psel, penable, pwrite, sw_on, er, st;
    logic        pready, pslverr, ovf_stop_sw, op_resume, ovf_lamp, halt_lamp;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  wait_cyc;
    logic [47:0] w;
    logic [14:0] p;
    int          err_count, n_compared, halts;
    aoc_row_t    rows [16];
    aoc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ovf_stop_sw, .op_resume, .ovf_lamp, .halt_lamp);
    aoc_console i_con (.pclk, .presetn, .sw_on, .wait_cyc, .halt_lamp, .ovf_stop_sw,
        .op_resume, .halts);
    // ----
    // Bus tasks
    // ----
    task automatic close_out();
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // An idle cycle follows each transfer so no strobe is driven twice at one edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            err_count++;
            close_out();
        end
        @(posedge pclk);
    endtask
    task automatic put(input logic [7:0] a, input logic [47:0] v);
        xfer(1'b1, a, v[31:0]);
        xfer(1'b1, a + 8'h04, {16'h0000, v[47:32]});
    endtask
    task automatic get(input logic [7:0] a, output logic [47:0] v);
        xfer(1'b0, a, 32'h0000_0000);
        v[31:0] = rd;
        xfer(1'b0, a + 8'h04, 32'h0000_0000);
        v[47:32] = rd[15:0];
    endtask
    task automatic run(input aoc_op_t op, input logic [14:0] t);
        int n;
        n = 0;
        xfer(1'b1, 8'h00, {1'b0, t, 10'h000, st, op});
        do begin
            xfer(1'b0, 8'h04, 32'h0000_0000);
            n++;
        end while (rd[3] !== 1'b0 && n < 100);
        if (n >= 100) begin
            err_count++;
            close_out();
        end
    endtask
    task automatic add_pair(input logic [47:0] a);
        put(8'h08, a);
        put(8'h18, ONE);
        run(op_add, 15'h0000);
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, sw_on, st, paddr, pwdata, wait_cyc} = '0;
        rows = '{'{op_add, MX, Z0, ONE, MN, Z0, 1'b1}, '{op_index_add_left_half, Z0, Z0, LH, LH, Z0, 1'b0},
            '{op_sub, MN, Z0, ONE, MX, Z0, 1'b1}, '{op_index_add_right_half, Z0, Z0, ONE, ONE, Z0, 1'b0},
            '{op_multiply, MN, Z0, MN, MN, Z0, 1'b1}, '{op_index_sub_left_half, Z0, Z0, LH,
            48'hFFFF_FF00_0000, Z0, 1'b0}, '{op_multiply_then_add, HF, MN, MN, NH, Z0, 1'b1},
            '{op_index_sub_right_half, Z0, Z0, ONE, 48'h0000_00FF_FFFF, Z0, 1'b0},
            '{op_div_single, HF, MX, QT, QT, Z0, 1'b1}, '{op_multiply, HF, Z0, HF, QT, Z0, 1'b0},
            '{op_div_double, 48'h4000_0000_0001, Z0, QT, QT, MN, 1'b1},
            '{op_div_single, NH, Z0, HF, NH, MN, 1'b0}, '{op_shift_left, HF, Z0, Z0, MN, Z0, 1'b1},
            '{op_div_single, NH, Z0, NH, NH, MX, 1'b0}, '{op_shift_right, MN, Z0, Z0, NH, Z0, 1'b0},
            '{op_multiply_then_subtract, Z0, HF, HF, 48'hE000_0000_0000, Z0, 1'b0}};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, 8'h04, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        xfer(1'b0, 8'h40, 32'h0000_0000);
        `CHK(er, 1'b1)
        foreach (rows[i]) begin
            put(8'h08, rows[i].a);
            put(8'h10, rows[i].e);
            put(8'h18, rows[i].o);
            run(rows[i].op, 15'h0000);
            get(8'h08, w);
            `CHK(w, rows[i].ra)
            if (rows[i].op inside {op_div_single, op_div_double}) begin
                get(8'h10, w);
                `CHK(w, rows[i].re)
            end
            `CHK(ovf_lamp, rows[i].v)
        end
        // Store option: the shifted extension replaces the divisor
        st = 1'b1;
        put(8'h08, 48'h4000_0000_0001);
        put(8'h18, QT);
        run(op_div_double, 15'h0000);
        get(8'h18, w);
        `CHK(w, MN)
        st = 1'b0;
        for (int k = 0; k < 2; k++) begin
            add_pair(k ? MX : Z0);
            xfer(1'b0, 8'h20, 32'h0000_0000);
            p = rd[14:0];
            run(op_jump_if_overflow, 15'h0100);
            xfer(1'b0, 8'h20, 32'h0000_0000);
            `CHK(rd[14:0], k ? 15'h0100 : p + 15'h0001)
            run(op_jump_if_no_overflow, 15'h0200);
            xfer(1'b0, 8'h20, 32'h0000_0000);
            `CHK(rd[14:0], k ? 15'h0101 : 15'h0200)
        end
        run(op_inhibit_overflow_clear, 15'h0000);
        xfer(1'b0, 8'h04, 32'h0000_0000);
        `CHK(rd[1:0], 2'b10)
        sw_on <= 1'b1;
        add_pair(MX);
        add_pair(Z0);
        run(op_nop, 15'h0000);
        `CHK(ovf_lamp, 1'b1)
        `CHK(halts, 0)
        run(op_allow_overflow_clear, 15'h0000);
        xfer(1'b0, 8'h04, 32'h0000_0000);
        `CHK(rd[1:0], 2'b01)
        for (int k = 0; k < 2; k++) begin
            wait_cyc <= k ? 4'h6 : 4'h0;
            add_pair(MX);
            add_pair(Z0);
            `CHK(halts, k + 1)
            get(8'h08, w);
            `CHK(w, ONE)
            `CHK(ovf_lamp, 1'b0)
        end
        add_pair(MX);
        run(op_jump_if_overflow, 15'h0300);
        xfer(1'b0, 8'h20, 32'h0000_0000);
        `CHK(rd[14:0], 15'h0300)
        sw_on <= 1'b0;
        add_pair(MX);
        add_pair(Z0);
        `CHK(halts, 2)
        close_out();
    end
endmodule
`default_nettype wire
